//--- ltc_lite_timer.sv
/*
 * lite timer: timebase counter 1 with selectable period, auto-reload
 * counter 2, 8-bit input capture, three interrupt lines, all registers
 * reached over an AXI4-Lite slave.
 * assumes aclk is the oscillator, halt_mode and cpu_irq_mask come from
 * logic on the same clock, capture_pin is asynchronous.
 */
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// Behaviour
// - counter 1 counts from zero every 32 cycles
// - counter 1 overflows wrapping from F9h to 00h
// - period select doubles counter 1 overflow interval
// - counter 1 overflow sets flag, optional interrupt
// - reading control/status 1 clears tick 1 flag
// - pin edge latches counter 1, sets capture flag
// - capture interrupt optional; value read clears flag
// - no new capture while capture flag set
// - counter 2 readable, starts from reload value
// - counter 2 reloads on wrap from FFh
// - reload write applies only at next overflow
// - reload sets counter 2 period in steps
// - counter 2 overflow sets flag, optional interrupt
// - reading control/status 2 clears tick 2 flag
// - software writes never change tick 2 flag
// - three separate interrupt request lines
// - interrupt needs enable and cleared global mask
// - halt stops counters, other modes keep running
// - period select gives 8000 or 16000 cycles
module ltc_lite_timer
    import ltc_pkg::*;
(
    input wire logic aclk,          // oscillator clock
    input wire logic aresetn,       // sync reset, active low
    input wire logic [7:0] awaddr,  // write address
    input wire logic awvalid,       // write address valid
    output logic awready,           // write address ready
    input wire logic [31:0] wdata,  // write data
    input wire logic [3:0] wstrb,   // write byte strobes
    input wire logic wvalid,        // write data valid
    output logic wready,            // write data ready
    output logic [1:0] bresp,       // write response
    output logic bvalid,            // write response valid
    input wire logic bready,        // write response ready
    input wire logic [7:0] araddr,  // read address
    input wire logic arvalid,       // read address valid
    output logic arready,           // read address ready
    output logic [31:0] rdata,      // read data
    output logic [1:0] rresp,       // read response
    output logic rvalid,            // read data valid
    input wire logic rready,        // read data ready
    input wire logic capture_pin,   // asynchronous capture input
    input wire logic halt_mode,     // cpu in halt, counters stop
    input wire logic cpu_irq_mask,  // global interrupt mask
    output logic irq_tick1,         // timebase 1 interrupt request
    output logic irq_tick2,         // timebase 2 interrupt request
    output logic irq_capture        // capture interrupt request
);

    // --------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------
    function automatic ltc_sel_t decode(input logic [7:0] addr);
        ltc_sel_t sel;
        sel = LTC_SEL_NONE;
        if (addr == LTC_ADDR_T2CS) begin
            sel = LTC_SEL_T2CS;
        end else if (addr == LTC_ADDR_RELOAD) begin
            sel = LTC_SEL_RELOAD;
        end else if (addr == LTC_ADDR_CNT2) begin
            sel = LTC_SEL_CNT2;
        end else if (addr == LTC_ADDR_T1CS) begin
            sel = LTC_SEL_T1CS;
        end else if (addr == LTC_ADDR_CAP) begin
            sel = LTC_SEL_CAP;
        end
        return sel;
    endfunction

    logic tick;
    logic [7:0] cnt1;
    logic half;
    logic t1_ovf;
    logic [7:0] cnt2;
    logic t2_ovf;
    logic [7:0] reload;
    logic period_select;
    logic tick1_irq_en;
    logic tick2_irq_en;
    logic capture_irq_en;
    logic tick1_flag;
    logic tick2_flag;
    logic capture_flag;
    logic [7:0] capture_value;

    // --------------------------------------------------------------
    // write channel
    // --------------------------------------------------------------
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_do;
    ltc_sel_t wr_sel;
    logic wr_lane;

    assign awready = !aw_full && !bvalid;
    assign wready = !w_full && !bvalid;
    assign wr_do = aw_full && w_full && !bvalid;
    assign wr_sel = decode(aw_addr);
    assign wr_lane = wr_do && w_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
        end else if (awvalid && awready) begin
            aw_full <= 1'b1;
            aw_addr <= awaddr;
        end else if (wr_do) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (wvalid && wready) begin
            w_full <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (wr_do) begin
            w_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= LTC_RESP_OKAY;
        end else if (wr_do) begin
            bvalid <= 1'b1;
            bresp <= (wr_sel == LTC_SEL_NONE) ? LTC_RESP_SLVERR
                                              : LTC_RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // read channel, reads of status and capture clear flags
    // --------------------------------------------------------------
    logic rd_take;
    ltc_sel_t rd_sel;
    logic [7:0] rd_byte;
    logic clr_t1;
    logic clr_t2;
    logic clr_cap;

    assign arready = !rvalid;
    assign rd_take = arvalid && arready;
    assign rd_sel = decode(araddr);
    assign clr_t1 = rd_take && rd_sel == LTC_SEL_T1CS;
    assign clr_t2 = rd_take && rd_sel == LTC_SEL_T2CS;
    assign clr_cap = rd_take && rd_sel == LTC_SEL_CAP;

    always_comb begin
        rd_byte = 8'h00;
        case (rd_sel)
            LTC_SEL_T2CS: begin
                rd_byte[LTC_T2_EN_BIT] = tick2_irq_en;
                rd_byte[LTC_T2_FLAG_BIT] = tick2_flag;
            end
            LTC_SEL_RELOAD: rd_byte = reload;
            LTC_SEL_CNT2: rd_byte = cnt2;
            LTC_SEL_T1CS: begin
                rd_byte[LTC_CAP_EN_BIT] = capture_irq_en;
                rd_byte[LTC_CAP_FLAG_BIT] = capture_flag;
                rd_byte[LTC_PSEL_BIT] = period_select;
                rd_byte[LTC_T1_EN_BIT] = tick1_irq_en;
                rd_byte[LTC_T1_FLAG_BIT] = tick1_flag;
            end
            LTC_SEL_CAP: rd_byte = capture_value;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= LTC_RESP_OKAY;
        end else if (rd_take) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= (rd_sel == LTC_SEL_NONE) ? LTC_RESP_SLVERR
                                              : LTC_RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // software controls; flag bits are not writable
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_select <= LTC_BIT_RST;
            tick1_irq_en <= LTC_BIT_RST;
            capture_irq_en <= LTC_BIT_RST;
        end else if (wr_lane && wr_sel == LTC_SEL_T1CS) begin
            period_select <= w_data[LTC_PSEL_BIT];
            tick1_irq_en <= w_data[LTC_T1_EN_BIT];
            capture_irq_en <= w_data[LTC_CAP_EN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick2_irq_en <= LTC_BIT_RST;
        end else if (wr_lane && wr_sel == LTC_SEL_T2CS) begin
            tick2_irq_en <= w_data[LTC_T2_EN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload <= LTC_RELOAD_RST;
        end else if (wr_lane && wr_sel == LTC_SEL_RELOAD) begin
            reload <= w_data[7:0];
        end
    end

    // --------------------------------------------------------------
    // prescaler and timebase counter 1
    // --------------------------------------------------------------
    ltc_prescale ltc_prescale_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .halt_mode(halt_mode),
        .tick(tick)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt1 <= LTC_CNT_RST;
            half <= 1'b0;
        end else if (tick) begin
            if (cnt1 == LTC_CNT1_TOP) begin
                cnt1 <= LTC_CNT_RST;
                half <= !half;
            end else begin
                cnt1 <= 8'(cnt1 + 1'b1);
            end
        end
    end

    // long period: only every second wrap counts as an overflow
    assign t1_ovf = tick && cnt1 == LTC_CNT1_TOP
                    && (!period_select || half);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick1_flag <= LTC_BIT_RST;
        end else if (t1_ovf) begin
            tick1_flag <= 1'b1;
        end else if (clr_t1) begin
            tick1_flag <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // auto-reload counter 2
    // --------------------------------------------------------------
    assign t2_ovf = tick && cnt2 == LTC_CNT2_TOP;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt2 <= LTC_RELOAD_RST;
        end else if (t2_ovf) begin
            cnt2 <= reload;
        end else if (tick) begin
            cnt2 <= 8'(cnt2 + 1'b1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick2_flag <= LTC_BIT_RST;
        end else if (t2_ovf) begin
            tick2_flag <= 1'b1;
        end else if (clr_t2) begin
            tick2_flag <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // input capture
    // --------------------------------------------------------------
    ltc_capture ltc_capture_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .capture_pin(capture_pin),
        .count_in(cnt1),
        .clear(clr_cap),
        .capture_flag(capture_flag),
        .capture_value(capture_value)
    );

    // --------------------------------------------------------------
    // interrupt lines, one per event
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_tick1 <= 1'b0;
            irq_tick2 <= 1'b0;
            irq_capture <= 1'b0;
        end else begin
            irq_tick1 <= tick1_flag && tick1_irq_en
                         && !cpu_irq_mask;
            irq_tick2 <= tick2_flag && tick2_irq_en
                         && !cpu_irq_mask;
            irq_capture <= capture_flag && capture_irq_en
                           && !cpu_irq_mask;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_cnt1_wrap: assert property (
        (tick && cnt1 == 8'hf9) |=> cnt1 == 8'h00)
        else $error("counter 1 did not wrap at f9");
    a_long_skip: assert property (
        (tick && cnt1 == 8'hf9 && period_select && !half
         && !tick1_flag) |=> !tick1_flag)
        else $error("long period overflowed early");
    a_t1_set: assert property (
        t1_ovf |=> tick1_flag)
        else $error("tick 1 flag not set on overflow");
    a_t1_clear: assert property (
        (clr_t1 && !t1_ovf) |=> !tick1_flag)
        else $error("tick 1 flag not cleared by read");
    a_set_wins: assert property (
        (clr_t2 && t2_ovf) |=> tick2_flag)
        else $error("tick 2 event lost under read clear");
    a_cnt2_reload: assert property (
        t2_ovf |=> cnt2 == $past(reload))
        else $error("counter 2 did not reload");
    a_cnt2_count: assert property (
        (tick && cnt2 != 8'hff) |=> cnt2 == 8'($past(cnt2) + 1))
        else $error("counter 2 disturbed between overflows");
    a_t2_hw_only: assert property (
        $rose(tick2_flag) |-> $past(t2_ovf))
        else $error("tick 2 flag set without overflow");
    a_irq_gate: assert property (
        irq_tick2 |-> $past(tick2_irq_en) && !$past(cpu_irq_mask))
        else $error("tick 2 irq without enable or with mask");

    c_t1_long: cover property (t1_ovf && period_select);
    c_t2_reload: cover property (t2_ovf && reload != 8'h00);
    c_irq_cap: cover property (irq_capture);

endmodule

//--- ltc_pkg.sv
/*
 * constants shared by the lite timer: prescale, counter limits, register
 * indices and byte addresses, field positions, reset values, bus codes.
 * assumes the system clock is the oscillator that the prescaler divides.
 */
package ltc_pkg;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int LTC_PRESCALE = 32;
    localparam int LTC_DIV_W = 5;
    // short timebase period in oscillator cycles, long one is double
    localparam int LTC_T1_SHORT_OSC = 8000;
    localparam int LTC_T1_LONG_OSC = 16000;
    localparam logic [7:0] LTC_CNT1_TOP =
        8'(LTC_T1_SHORT_OSC / LTC_PRESCALE - 1);
    localparam logic [7:0] LTC_CNT2_TOP = 8'hff;
    localparam logic [7:0] LTC_CNT_RST = 8'h00;
    localparam logic [7:0] LTC_RELOAD_RST = 8'h00;
    localparam logic [7:0] LTC_CAP_RST = 8'h00;

    // --------------------------------------------------------------
    // register map: index, byte address is four times the index
    // --------------------------------------------------------------
    localparam logic [7:0] LTC_IDX_T2CS = 8'h08;
    localparam logic [7:0] LTC_IDX_RELOAD = 8'h09;
    localparam logic [7:0] LTC_IDX_CNT2 = 8'h0a;
    localparam logic [7:0] LTC_IDX_T1CS = 8'h0b;
    localparam logic [7:0] LTC_IDX_CAP = 8'h0c;
    localparam logic [7:0] LTC_ADDR_T2CS = 8'(4 * LTC_IDX_T2CS);
    localparam logic [7:0] LTC_ADDR_RELOAD = 8'(4 * LTC_IDX_RELOAD);
    localparam logic [7:0] LTC_ADDR_CNT2 = 8'(4 * LTC_IDX_CNT2);
    localparam logic [7:0] LTC_ADDR_T1CS = 8'(4 * LTC_IDX_T1CS);
    localparam logic [7:0] LTC_ADDR_CAP = 8'(4 * LTC_IDX_CAP);

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int LTC_T2_EN_BIT = 1;
    localparam int LTC_T2_FLAG_BIT = 0;
    localparam int LTC_CAP_EN_BIT = 7;
    localparam int LTC_CAP_FLAG_BIT = 6;
    localparam int LTC_PSEL_BIT = 5;
    localparam int LTC_T1_EN_BIT = 4;
    localparam int LTC_T1_FLAG_BIT = 3;
    localparam logic LTC_BIT_RST = 1'b0;

    // --------------------------------------------------------------
    // bus answers and register select
    // --------------------------------------------------------------
    localparam logic [1:0] LTC_RESP_OKAY = 2'b00;
    localparam logic [1:0] LTC_RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        LTC_SEL_NONE = 3'b000,
        LTC_SEL_T2CS = 3'b001,
        LTC_SEL_RELOAD = 3'b010,
        LTC_SEL_CNT2 = 3'b011,
        LTC_SEL_T1CS = 3'b100,
        LTC_SEL_CAP = 3'b101
    } ltc_sel_t;

endpackage

//--- ltc_prescale.sv
/*
 * divide-by-32 enable for the timer counters, frozen in halt.
 * assumes halt_mode comes from logic on the same clock.
 */
`timescale 1ns/1ps
module ltc_prescale
    import ltc_pkg::*;
(
    input wire logic aclk,      // oscillator clock
    input wire logic aresetn,   // sync reset, active low
    input wire logic halt_mode, // stops the divider
    output logic tick           // one-cycle enable every 32 cycles
);

    logic [LTC_DIV_W-1:0] div;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div <= '0;
        end else if (!halt_mode) begin
            div <= LTC_DIV_W'(div + 1'b1);
        end
    end

    assign tick = !halt_mode && (div == LTC_DIV_W'(LTC_PRESCALE - 1));

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_tick_spacing: assert property (
        @(posedge aclk) disable iff (!aresetn) tick |=> !tick [*8])
        else $error("prescale ticks closer than expected");
    a_halt_freeze: assert property (
        @(posedge aclk) disable iff (!aresetn)
        halt_mode |=> (div == $past(div)))
        else $error("divider moved in halt");
    c_tick: cover property (@(posedge aclk) disable iff (!aresetn) tick);

endmodule

//--- ltc_capture.sv
/*
 * input capture: synchronises the capture pin, detects either edge,
 * latches counter 1 and holds the flag until the value is read.
 * assumes clear is a one-cycle pulse from the register read.
 */
`timescale 1ns/1ps
module ltc_capture
    import ltc_pkg::*;
(
    input wire logic aclk,           // oscillator clock
    input wire logic aresetn,        // sync reset, active low
    input wire logic capture_pin,    // asynchronous capture input
    input wire logic [7:0] count_in, // counter 1 value
    input wire logic clear,          // capture value read
    output logic capture_flag,       // a capture is pending
    output logic [7:0] capture_value // last accepted capture
);

    logic sync_a;
    logic sync_b;
    logic pin_last;
    logic take;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            pin_last <= 1'b0;
        end else begin
            sync_a <= capture_pin;
            sync_b <= sync_a;
            pin_last <= sync_b;
        end
    end

    // both edges count; blocked while a capture is still unread
    assign take = (sync_b ^ pin_last) && !capture_flag;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_value <= LTC_CAP_RST;
        end else if (take) begin
            capture_value <= count_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_flag <= LTC_BIT_RST;
        end else if (take) begin
            capture_flag <= 1'b1;
        end else if (clear) begin
            capture_flag <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_cap_latch: assert property (
        @(posedge aclk) disable iff (!aresetn)
        take |=> capture_flag && capture_value == $past(count_in))
        else $error("capture did not latch counter");
    a_cap_blocked: assert property (
        @(posedge aclk) disable iff (!aresetn)
        capture_flag |=> $stable(capture_value))
        else $error("capture value changed while flag set");
    c_capture: cover property (@(posedge aclk) disable iff (!aresetn) take);

endmodule

//--- ltc_lite_timer_bench.sv
/*
 * self-checking bench for the lite timer: register reset values, bus
 * answers, tick timing, reload, capture, irq mask and halt.
 * assumes ltc_pkg and ltc_lite_timer are compiled first.
 */
`timescale 1ns/1ps
module ltc_lite_timer_bench;
    import ltc_pkg::*;
    logic aclk = 0, aresetn = 0, capture_pin = 0;
    logic halt_mode = 0, cpu_irq_mask = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic irq_tick1, irq_tick2, irq_capture;
    logic [2:0] irqs;
    int err_count = 0, checked = 0, cyc = 0, a1, a2, ca;

    assign irqs = {irq_capture, irq_tick2, irq_tick1};

    ltc_lite_timer ltc_lite_timer_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .capture_pin(capture_pin), .halt_mode(halt_mode),
        .cpu_irq_mask(cpu_irq_mask), .irq_tick1(irq_tick1),
        .irq_tick2(irq_tick2), .irq_capture(irq_capture)
    );

    always #20 aclk = ~aclk;

    // longest path is two long tick1 periods plus the startup
    always @(posedge aclk) begin
        cyc <= aresetn ? cyc + 1 : 0;
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end

    // --------------------------------------------------------------
    // bus and check tasks
    // --------------------------------------------------------------
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask

    // outputs read right after the edge still hold the sampled values
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        chk("bresp", {30'h0, LTC_RESP_OKAY}, {30'h0, r});
    endtask

    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, e, d);
        chk("rresp", {30'h0, LTC_RESP_OKAY}, {30'h0, r});
    endtask

    task wait_lvl(input int w, input logic lv, output int at);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (irqs[w] !== lv && n < 20000);
        at = cyc;
        chk("irq level", {31'h0, lv}, {31'h0, irqs[w]});
    endtask

    task wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rdc(8'(LTC_ADDR_T2CS + 4 * i), 32'h0, "reset value");
        end
        rd(8'h00);
        chk("unmapped resp", {30'h0, LTC_RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        wr(LTC_ADDR_T2CS, 32'h3);
        rdc(LTC_ADDR_T2CS, 32'h2, "tick2 ctl");
        wr(LTC_ADDR_RELOAD, 32'hf0);
        rd(LTC_ADDR_CNT2);
        chk("cnt2 untouched", 1, 32'(d < 32'h10));
        // a write with lane 0 off must leave the reload value alone
        wstrb <= 4'h0;
        wr(LTC_ADDR_RELOAD, 32'h55);
        wstrb <= 4'hf;
        rdc(LTC_ADDR_RELOAD, 32'hf0, "strobe off");
        wr(LTC_ADDR_T1CS, 32'hd8);
        rdc(LTC_ADDR_T1CS, 32'h90, "tick1 ctl");
        // capture away from a tick so the latched count is unambiguous
        while (cyc % 32 != 10) @(posedge aclk);
        capture_pin <= 1'b1;
        ca = cyc;
        wait_lvl(2, 1'b1, a1);
        repeat (200) @(posedge aclk);
        capture_pin <= 1'b0;
        repeat (10) @(posedge aclk);
        rdc(LTC_ADDR_T1CS, 32'hd0, "capture flag");
        rdc(LTC_ADDR_CAP, 32'(ca / 32), "capture value");
        rdc(LTC_ADDR_T1CS, 32'h90, "capture clear");
        wait_lvl(2, 1'b0, a1);
        wait_lvl(0, 1'b1, a1);
        chk("tick1 time", 1, 32'(a1 >= 7995 && a1 <= 8005));
        rdc(LTC_ADDR_T1CS, 32'h98, "tick1 flag");
        rdc(LTC_ADDR_T1CS, 32'h90, "tick1 clear");
        wait_lvl(1, 1'b1, a1);
        chk("tick2 time", 1, 32'(a1 >= 8187 && a1 <= 8197));
        cpu_irq_mask <= 1'b1;
        wait_lvl(1, 1'b0, a2);
        chk("mask drop", 1, 32'(a2 - a1 <= 4));
        cpu_irq_mask <= 1'b0;
        wait_lvl(1, 1'b1, a2);
        wr(LTC_ADDR_T2CS, 32'h2);
        rdc(LTC_ADDR_T2CS, 32'h3, "tick2 flag");
        rdc(LTC_ADDR_T2CS, 32'h2, "tick2 clear");
        wait_lvl(1, 1'b0, a2);
        wait_lvl(1, 1'b1, a2);
        chk("tick2 period", 512, 32'(a2 - a1));
        wr(LTC_ADDR_T2CS, 32'h0);
        wr(LTC_ADDR_T1CS, 32'hb0);
        // the first long period may be odd, so time the second one
        wait_lvl(0, 1'b1, a1);
        rdc(LTC_ADDR_T1CS, 32'hb8, "tick1 long");
        wait_lvl(0, 1'b0, a2);
        wait_lvl(0, 1'b1, a2);
        chk("tick1 period", 16000, 32'(a2 - a1));
        halt_mode <= 1'b1;
        rd(LTC_ADDR_CNT2);
        a1 = d;
        repeat (100) @(posedge aclk);
        rd(LTC_ADDR_CNT2);
        chk("halt freeze", 32'(a1), d);
        halt_mode <= 1'b0;
        repeat (100) @(posedge aclk);
        rd(LTC_ADDR_CNT2);
        chk("halt resume", 1, 32'(d != 32'(a1)));
        wrap_up();
    end
endmodule
